// ### hdl/lane_error_status.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "lane_error_status_defs.svh"

// Summary of operation
// - A lane's disparity flag is set on a running disparity error, only in L0.
// - A lane's decode flag is set when a received symbol fails to decode.
// - Decode flags are set only in L0, Configuration, Disabled or Hot-Reset.
// - A lane's sticky underflow flag is set on zero-byte insertion in L0.
// - A lane's sticky overflow flag is set on dropped bytes in L0.
// - Upper four lanes are valid only on even ports in merged mode.
// - Coding flags reset to zero and clear on write-one, write-zero keeps.
// - Elastic flags reset to zero, clear on write-one, survive soft reset.
module lane_error_status (
  input  wire logic                                clk_in,
  input  wire logic                                rst_b_in,
  input  wire logic                                soft_rst_b_in,
  input  wire lane_error_status_pkg::ltssm_state_t ltssm_in,
  input  wire logic                                port_odd_in,
  input  wire logic                                merged_mode_in,
  input  wire lane_error_status_pkg::lane_vec_t    disparity_err_in,
  input  wire lane_error_status_pkg::lane_vec_t    decode_err_in,
  input  wire lane_error_status_pkg::lane_vec_t    underflow_in,
  input  wire lane_error_status_pkg::lane_vec_t    overflow_in,
  input  wire logic [`LES_ADDR_W-1:0]              addr_in,
  input  wire logic [31:0]                         wdata_in,
  input  wire logic                                wr_in,
  input  wire logic                                rd_in,
  output logic [31:0]                              rdata_out,
  output logic                                     irq_out,
  output lane_error_status_pkg::lane_vec_t         disparity_error_flags_out,
  output lane_error_status_pkg::lane_vec_t         symbol_decode_error_flags_out,
  output lane_error_status_pkg::lane_vec_t         rx_underflow_flags_out,
  output lane_error_status_pkg::lane_vec_t         rx_overflow_flags_out,
  output lane_error_status_pkg::lane_vec_t         lane_valid_out
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------

  // Places the two lane fields of a status word, leaving reserved bits zero.
  function automatic logic [31:0] pack_fields(
    input lane_error_status_pkg::lane_vec_t low,
    input lane_error_status_pkg::lane_vec_t high
  );
    logic [31:0] word;
    word = `LES_WORD_RESET;
    word[`LES_LOW_MSB:`LES_LOW_LSB]   = low;
    word[`LES_HIGH_MSB:`LES_HIGH_LSB] = high;
    return word;
  endfunction : pack_fields

  // Write-one-to-clear with set priority, so an event in the clearing
  // cycle is never lost.
  function automatic lane_error_status_pkg::lane_vec_t w1c_update(
    input lane_error_status_pkg::lane_vec_t cur,
    input lane_error_status_pkg::lane_vec_t set,
    input lane_error_status_pkg::lane_vec_t clr,
    input logic                             hit
  );
    lane_error_status_pkg::lane_vec_t kept;
    kept = hit ? (cur & ~clr) : cur;
    return kept | set;
  endfunction : w1c_update

  // Plain write of a mask field.
  function automatic lane_error_status_pkg::lane_vec_t field_write(
    input lane_error_status_pkg::lane_vec_t cur,
    input lane_error_status_pkg::lane_vec_t val,
    input logic                             hit
  );
    return hit ? val : cur;
  endfunction : field_write

  // --------------------------------------------------------------------------
  // Event qualification by link state and lane ownership
  // --------------------------------------------------------------------------
  lane_error_status_pkg::lane_vec_t disparity_set;
  lane_error_status_pkg::lane_vec_t decode_set;
  lane_error_status_pkg::lane_vec_t underflow_set;
  lane_error_status_pkg::lane_vec_t overflow_set;
  lane_error_status_pkg::lane_vec_t lane_valid;

  lane_event_qualifier u_qualifier (
    .ltssm_in          (ltssm_in),
    .port_odd_in       (port_odd_in),
    .merged_mode_in    (merged_mode_in),
    .disparity_raw_in  (disparity_err_in),
    .decode_raw_in     (decode_err_in),
    .underflow_raw_in  (underflow_in),
    .overflow_raw_in   (overflow_in),
    .disparity_set_out (disparity_set),
    .decode_set_out    (decode_set),
    .underflow_set_out (underflow_set),
    .overflow_set_out  (overflow_set),
    .lane_valid_out    (lane_valid)
  );

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  logic hit_coding;
  logic hit_elastic;
  logic hit_coding_en;
  logic hit_elastic_en;
  logic wr_coding;
  logic wr_elastic;
  logic wr_coding_en;
  logic wr_elastic_en;

  lane_error_status_pkg::lane_vec_t wr_low;
  lane_error_status_pkg::lane_vec_t wr_high;

  assign hit_coding     = (addr_in == `LES_CODING_OFS);
  assign hit_elastic    = (addr_in == `LES_ELASTIC_OFS);
  assign hit_coding_en  = (addr_in == `LES_CODING_MASK_OFS);
  assign hit_elastic_en = (addr_in == `LES_ELASTIC_MASK_OFS);

  assign wr_coding      = wr_in && hit_coding;
  assign wr_elastic     = wr_in && hit_elastic;
  assign wr_coding_en   = wr_in && hit_coding_en;
  assign wr_elastic_en  = wr_in && hit_elastic_en;

  assign wr_low  = wdata_in[`LES_LOW_MSB:`LES_LOW_LSB];
  assign wr_high = wdata_in[`LES_HIGH_MSB:`LES_HIGH_LSB];

  // --------------------------------------------------------------------------
  // State update
  // --------------------------------------------------------------------------
  lane_error_status_pkg::les_state_t state_q;
  lane_error_status_pkg::les_state_t state_d;

  logic [31:0] coding_word;
  logic [31:0] elastic_word;
  logic [31:0] coding_en_word;
  logic [31:0] elastic_en_word;
  logic        pending;

  assign coding_word     = pack_fields(state_q.disparity, state_q.decode);
  assign elastic_word    = pack_fields(state_q.underflow, state_q.overflow);
  assign coding_en_word  = pack_fields(state_q.disparity_en,
                                       state_q.decode_en);
  assign elastic_en_word = pack_fields(state_q.underflow_en,
                                       state_q.overflow_en);

  always_comb begin
    state_d = state_q;

    state_d.disparity = w1c_update(state_q.disparity, disparity_set,
                                   wr_low, wr_coding);
    state_d.decode    = w1c_update(state_q.decode, decode_set,
                                   wr_high, wr_coding);

    state_d.underflow = w1c_update(state_q.underflow, underflow_set,
                                   wr_low, wr_elastic);
    state_d.overflow  = w1c_update(state_q.overflow, overflow_set,
                                   wr_high, wr_elastic);

    state_d.disparity_en = field_write(state_q.disparity_en, wr_low,
                                       wr_coding_en);
    state_d.decode_en    = field_write(state_q.decode_en, wr_high,
                                       wr_coding_en);
    state_d.underflow_en = field_write(state_q.underflow_en, wr_low,
                                       wr_elastic_en);
    state_d.overflow_en  = field_write(state_q.overflow_en, wr_high,
                                       wr_elastic_en);

    // Read data stand for one cycle only; unmapped addresses read zero.
    state_d.rdata = `LES_WORD_RESET;
    if (rd_in) begin
      unique case (1'b1)
        hit_coding: begin
          state_d.rdata = coding_word;
        end
        hit_elastic: begin
          state_d.rdata = elastic_word;
        end
        hit_coding_en: begin
          state_d.rdata = coding_en_word;
        end
        hit_elastic_en: begin
          state_d.rdata = elastic_en_word;
        end
        default: begin
          state_d.rdata = `LES_WORD_RESET;
        end
      endcase
    end

    // The interrupt follows the flags as they will stand next cycle, so a
    // clear drops the line without an extra cycle of stale assertion.
    pending =
      |(state_d.disparity & state_d.disparity_en) ||
      |(state_d.decode    & state_d.decode_en)    ||
      |(state_d.underflow & state_d.underflow_en) ||
      |(state_d.overflow  & state_d.overflow_en);
    state_d.irq = pending;

    // A soft reset clears everything except the sticky elastic flags.
    if (!soft_rst_b_in) begin
      state_d.disparity    = `LES_FIELD_RESET;
      state_d.decode       = `LES_FIELD_RESET;
      state_d.disparity_en = `LES_FIELD_RESET;
      state_d.decode_en    = `LES_FIELD_RESET;
      state_d.underflow_en = `LES_FIELD_RESET;
      state_d.overflow_en  = `LES_FIELD_RESET;
      state_d.rdata        = `LES_WORD_RESET;
      state_d.irq          = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_q.disparity    <= `LES_FIELD_RESET;
      state_q.decode       <= `LES_FIELD_RESET;
      state_q.underflow    <= `LES_FIELD_RESET;
      state_q.overflow     <= `LES_FIELD_RESET;
      state_q.disparity_en <= `LES_FIELD_RESET;
      state_q.decode_en    <= `LES_FIELD_RESET;
      state_q.underflow_en <= `LES_FIELD_RESET;
      state_q.overflow_en  <= `LES_FIELD_RESET;
      state_q.rdata        <= `LES_WORD_RESET;
      state_q.irq          <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign rdata_out                     = state_q.rdata;
  assign irq_out                       = state_q.irq;
  assign disparity_error_flags_out     = state_q.disparity;
  assign symbol_decode_error_flags_out = state_q.decode;
  assign rx_underflow_flags_out        = state_q.underflow;
  assign rx_overflow_flags_out         = state_q.overflow;
  assign lane_valid_out                = lane_valid;

endmodule : lane_error_status

// ### common/lane_error_status_defs.svh
`ifndef LANE_ERROR_STATUS_DEFS_SVH
`define LANE_ERROR_STATUS_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define LES_ADDR_W           12
`define LES_CODING_OFS       12'h51c
`define LES_ELASTIC_OFS      12'h520
`define LES_CODING_MASK_OFS  12'h524
`define LES_ELASTIC_MASK_OFS 12'h528

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LES_LANES            8
`define LES_LOW_LSB          0
`define LES_LOW_MSB          7
`define LES_HIGH_LSB         16
`define LES_HIGH_MSB         23

// ----------------------------------------------------------------------------
// Reset values and lane validity
// ----------------------------------------------------------------------------
`define LES_FIELD_RESET      8'h00
`define LES_WORD_RESET       32'h0000_0000
`define LES_LANES_ALL        8'hff
`define LES_LANES_LOWER      8'h0f

`endif

// ### common/lane_error_status_pkg.sv
package lane_error_status_pkg;

  // --------------------------------------------------------------------------
  // Link training states as driven by the port's state machine
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    LTSSM_DETECT        = 4'h0,
    LTSSM_POLLING       = 4'h1,
    LTSSM_CONFIGURATION = 4'h2,
    LTSSM_L0            = 4'h3,
    LTSSM_RECOVERY      = 4'h4,
    LTSSM_L0S           = 4'h5,
    LTSSM_L1            = 4'h6,
    LTSSM_L2            = 4'h7,
    LTSSM_DISABLED      = 4'h8,
    LTSSM_LOOPBACK      = 4'h9,
    LTSSM_HOT_RESET     = 4'ha
  } ltssm_state_t;

  typedef logic [7:0] lane_vec_t;

  // --------------------------------------------------------------------------
  // Complete state of the status block
  // --------------------------------------------------------------------------
  typedef struct packed {
    lane_vec_t   disparity;
    lane_vec_t   decode;
    lane_vec_t   underflow;
    lane_vec_t   overflow;
    lane_vec_t   disparity_en;
    lane_vec_t   decode_en;
    lane_vec_t   underflow_en;
    lane_vec_t   overflow_en;
    logic [31:0] rdata;
    logic        irq;
  } les_state_t;

endpackage : lane_error_status_pkg

// ### hdl/lane_event_qualifier.sv
`timescale 1ns/1ps
`include "lane_error_status_defs.svh"

module lane_event_qualifier (
  input  wire lane_error_status_pkg::ltssm_state_t ltssm_in,
  input  wire logic                                port_odd_in,
  input  wire logic                                merged_mode_in,
  input  wire lane_error_status_pkg::lane_vec_t    disparity_raw_in,
  input  wire lane_error_status_pkg::lane_vec_t    decode_raw_in,
  input  wire lane_error_status_pkg::lane_vec_t    underflow_raw_in,
  input  wire lane_error_status_pkg::lane_vec_t    overflow_raw_in,
  output lane_error_status_pkg::lane_vec_t         disparity_set_out,
  output lane_error_status_pkg::lane_vec_t         decode_set_out,
  output lane_error_status_pkg::lane_vec_t         underflow_set_out,
  output lane_error_status_pkg::lane_vec_t         overflow_set_out,
  output lane_error_status_pkg::lane_vec_t         lane_valid_out
);

  // Upper lanes carry no data unless an even port owns the merged pair.
  function automatic lane_error_status_pkg::lane_vec_t lanes_owned(
    input logic odd,
    input logic merged
  );
    if (!odd && merged) begin
      return `LES_LANES_ALL;
    end
    return `LES_LANES_LOWER;
  endfunction : lanes_owned

  logic in_l0;
  logic decode_window;

  assign in_l0 = (ltssm_in == lane_error_status_pkg::LTSSM_L0);

  assign decode_window = in_l0 ||
    (ltssm_in == lane_error_status_pkg::LTSSM_CONFIGURATION) ||
    (ltssm_in == lane_error_status_pkg::LTSSM_DISABLED) ||
    (ltssm_in == lane_error_status_pkg::LTSSM_HOT_RESET);

  assign lane_valid_out = lanes_owned(port_odd_in, merged_mode_in);

  assign disparity_set_out = in_l0 ? (disparity_raw_in & lane_valid_out)
                                   : `LES_FIELD_RESET;
  assign decode_set_out = decode_window ? (decode_raw_in & lane_valid_out)
                                        : `LES_FIELD_RESET;
  assign underflow_set_out = in_l0 ? (underflow_raw_in & lane_valid_out)
                                   : `LES_FIELD_RESET;
  assign overflow_set_out = in_l0 ? (overflow_raw_in & lane_valid_out)
                                  : `LES_FIELD_RESET;

endmodule : lane_event_qualifier

// ### tb/lane_link_partner.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Receive front end facing the link partner
// ----------------------------------------------------------------------------
// Turns one bench command into a one-cycle event pulse on the chosen lanes.
// Only one kind fires at a time so each flag field can be judged alone.
module lane_link_partner (
  input  wire logic                             clk_in,
  input  wire logic                             fire_in,
  input  wire logic [1:0]                       kind_in,
  input  wire lane_error_status_pkg::lane_vec_t lanes_in,
  output lane_error_status_pkg::lane_vec_t      disparity_out,
  output lane_error_status_pkg::lane_vec_t      decode_out,
  output lane_error_status_pkg::lane_vec_t      underflow_out,
  output lane_error_status_pkg::lane_vec_t      overflow_out
);
  always_ff @(posedge clk_in) begin
    disparity_out <= (fire_in && kind_in == 2'h0) ? lanes_in : 8'h00;
    decode_out    <= (fire_in && kind_in == 2'h1) ? lanes_in : 8'h00;
    underflow_out <= (fire_in && kind_in == 2'h2) ? lanes_in : 8'h00;
    overflow_out  <= (fire_in && kind_in == 2'h3) ? lanes_in : 8'h00;
  end
endmodule : lane_link_partner

// ### tb/lane_error_status_checker.sv
`timescale 1ns/1ps
`include "lane_error_status_defs.svh"

module lane_error_status_checker (
  input wire logic                                clk_in,
  input wire logic                                rst_b_in,
  input wire logic                                soft_rst_b_in,
  input wire lane_error_status_pkg::ltssm_state_t ltssm_in,
  input wire logic                                port_odd_in,
  input wire logic                                merged_mode_in,
  input wire logic [7:0]                          disparity_err_in,
  input wire logic [11:0]                         addr_in,
  input wire logic [31:0]                         wdata_in,
  input wire logic                                wr_in,
  input wire logic                                rd_in,
  input wire logic [31:0]                         rdata_out,
  input wire logic                                irq_out,
  input wire logic [7:0]                          disparity_error_flags_out,
  input wire logic [7:0]                          symbol_decode_error_flags_out,
  input wire logic [7:0]                          rx_underflow_flags_out,
  input wire logic [7:0]                          rx_overflow_flags_out,
  input wire logic [7:0]                          lane_valid_out
);
  logic [7:0]  dis_f;
  logic [7:0]  dec_f;
  logic [15:0] eb_f;
  logic [15:0] up_f;
  assign dis_f = disparity_error_flags_out;
  assign dec_f = symbol_decode_error_flags_out;
  assign eb_f  = {rx_underflow_flags_out, rx_overflow_flags_out};
  assign up_f  = {dis_f[7:4], dec_f[7:4], eb_f[15:12], eb_f[7:4]};

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in || !soft_rst_b_in);

  property p_disp_l0;
    |(dis_f & ~$past(dis_f))
      |-> $past(ltssm_in) == lane_error_status_pkg::LTSSM_L0;
  endproperty
  property p_disp_set;
    (ltssm_in == lane_error_status_pkg::LTSSM_L0 && |disparity_err_in[3:0])
      |=> (dis_f[3:0] & $past(disparity_err_in[3:0]))
          == $past(disparity_err_in[3:0]);
  endproperty
  property p_dec_state;
    |(dec_f & ~$past(dec_f)) |-> $past(ltssm_in) inside
      {4'h3, 4'h2, 4'h8, 4'ha};
  endproperty
  property p_eb_l0;
    |(eb_f & ~$past(eb_f))
      |-> $past(ltssm_in) == lane_error_status_pkg::LTSSM_L0;
  endproperty
  property p_upper_gate;
    |(up_f & ~$past(up_f)) |-> $past(!port_odd_in && merged_mode_in);
  endproperty
  property p_read_word;
    rd_in && addr_in == `LES_CODING_OFS
      |=> rdata_out == {8'h00, $past(dec_f), 8'h00, $past(dis_f)};
  endproperty
  property p_read_idle;
    !rd_in |=> rdata_out == 32'h0000_0000;
  endproperty
  property p_reserved;
    rd_in |=> (rdata_out & 32'hff00_ff00) == 32'h0000_0000;
  endproperty
  property p_w1c;
    wr_in && addr_in == `LES_CODING_OFS
      |=> (dis_f & $past(wdata_in[7:0] & ~disparity_err_in)) == 8'h00;
  endproperty
  property p_sticky;
    disable iff (!rst_b_in)
    |(~eb_f & $past(eb_f)) |-> $past(wr_in && addr_in == `LES_ELASTIC_OFS);
  endproperty
  property p_irq;
    irq_out |-> |{dis_f, dec_f, eb_f};
  endproperty

  a_disp_l0 : assert property (p_disp_l0)
    else $error("disparity flag set outside L0");
  a_disp_set : assert property (p_disp_set)
    else $error("disparity event did not set its flag");
  a_dec_state : assert property (p_dec_state)
    else $error("decode flag set in a barred state");
  a_eb_l0 : assert property (p_eb_l0)
    else $error("elastic flag set outside L0");
  a_upper_gate : assert property (p_upper_gate)
    else $error("upper lane flag set while invalid");
  a_read_word : assert property (p_read_word)
    else $error("coding status read word wrong");
  a_read_idle : assert property (p_read_idle)
    else $error("read data not zero outside read");
  a_reserved : assert property (p_reserved)
    else $error("reserved bits read nonzero");
  a_w1c : assert property (p_w1c)
    else $error("write one did not clear flag");
  a_sticky : assert property (p_sticky)
    else $error("elastic flag lost without write");
  a_irq : assert property (p_irq)
    else $error("interrupt high with no flag");

  c_disp : cover property (|(dis_f & ~$past(dis_f)));
  c_upper : cover property (|(up_f & ~$past(up_f)));
  c_irq : cover property ($rose(irq_out));
endmodule : lane_error_status_checker

bind lane_error_status lane_error_status_checker i_checker (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .soft_rst_b_in(soft_rst_b_in),
  .ltssm_in(ltssm_in), .port_odd_in(port_odd_in),
  .merged_mode_in(merged_mode_in), .disparity_err_in(disparity_err_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .irq_out(irq_out),
  .disparity_error_flags_out(disparity_error_flags_out),
  .symbol_decode_error_flags_out(symbol_decode_error_flags_out),
  .rx_underflow_flags_out(rx_underflow_flags_out),
  .rx_overflow_flags_out(rx_overflow_flags_out),
  .lane_valid_out(lane_valid_out));

// ### tb/lane_error_status_tb_top.sv
`timescale 1ns/1ps
`include "lane_error_status_defs.svh"

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
  fail_count++; \
  $display("Error t=%0t got %h exp %h", $time, got, exp); end end

module lane_error_status_tb_top;
  logic clk_in = 1'b0, rst_b_in = 1'b0, soft_rst_b_in = 1'b1;
  lane_error_status_pkg::ltssm_state_t ltssm_in =
    lane_error_status_pkg::LTSSM_L0;
  logic port_odd_in = 1'b0, merged_mode_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  logic fire = 1'b0;
  logic [1:0]  kind = 2'h0;
  logic [7:0]  lanes = 8'h00, dis_ev, dec_ev, und_ev, ovr_ev, lv, df, cf, uf, of;
  logic [11:0] addr_in = 12'h000;
  logic [31:0] wdata_in = 32'h0, rdata_out, rd_word, exp_word;
  logic [11:0] rst_addr [5] = '{`LES_CODING_OFS, `LES_ELASTIC_OFS,
    `LES_CODING_MASK_OFS, `LES_ELASTIC_MASK_OFS, 12'h530};
  logic        irq_out;
  int          fail_count = 0, n_checks = 0;
  // State codes follow the package encoding.
  typedef struct packed {
    logic [3:0] st; logic odd; logic mrg; logic [1:0] k;
    logic [7:0] ln; logic [7:0] ex;
  } row_t;
  row_t rows [12] = '{
    '{4'h3, 1'b0, 1'b1, 2'h0, 8'hff, 8'hff},
    '{4'h3, 1'b1, 1'b1, 2'h0, 8'hff, 8'h0f},
    '{4'h4, 1'b0, 1'b1, 2'h0, 8'h01, 8'h00},
    '{4'h2, 1'b0, 1'b1, 2'h1, 8'h03, 8'h03},
    '{4'h8, 1'b0, 1'b1, 2'h1, 8'h80, 8'h80},
    '{4'ha, 1'b0, 1'b1, 2'h1, 8'h05, 8'h05},
    '{4'h1, 1'b0, 1'b1, 2'h1, 8'h01, 8'h00},
    '{4'h3, 1'b0, 1'b0, 2'h1, 8'hf0, 8'h00},
    '{4'h3, 1'b0, 1'b1, 2'h2, 8'hff, 8'hff},
    '{4'h5, 1'b0, 1'b1, 2'h2, 8'h01, 8'h00},
    '{4'h3, 1'b1, 1'b1, 2'h3, 8'hff, 8'h0f},
    '{4'h6, 1'b0, 1'b1, 2'h3, 8'h01, 8'h00}};

  always #12.5 clk_in = ~clk_in;

  lane_link_partner i_lane_link_partner (.clk_in(clk_in), .fire_in(fire),
    .kind_in(kind), .lanes_in(lanes), .disparity_out(dis_ev),
    .decode_out(dec_ev), .underflow_out(und_ev), .overflow_out(ovr_ev));
  lane_error_status i_lane_error_status (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .soft_rst_b_in(soft_rst_b_in), .ltssm_in(ltssm_in),
    .port_odd_in(port_odd_in), .merged_mode_in(merged_mode_in),
    .disparity_err_in(dis_ev), .decode_err_in(dec_ev), .underflow_in(und_ev),
    .overflow_in(ovr_ev), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
    .disparity_error_flags_out(df), .symbol_decode_error_flags_out(cf),
    .rx_underflow_flags_out(uf), .rx_overflow_flags_out(of),
    .lane_valid_out(lv));

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in); addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
    @(posedge clk_in); wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clk_in); addr_in <= a; rd_in <= 1'b1;
    @(posedge clk_in); rd_in <= 1'b0;
    @(negedge clk_in); rd_word = rdata_out;
  endtask : rd
  task automatic inject(input logic [1:0] k, input logic [7:0] l);
    @(posedge clk_in); fire <= 1'b1; kind <= k; lanes <= l;
    @(posedge clk_in); fire <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask : inject
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (4000) @(posedge clk_in);
    fail_count++;
    final_report();
  end

  initial begin
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    foreach (rst_addr[i]) begin
      rd(rst_addr[i]);
      `CHK(rd_word, 32'h0)
    end
    foreach (rows[i]) begin
      @(posedge clk_in);
      ltssm_in <= lane_error_status_pkg::ltssm_state_t'(rows[i].st);
      port_odd_in <= rows[i].odd; merged_mode_in <= rows[i].mrg;
      wr(`LES_CODING_OFS, 32'hffff_ffff);
      wr(`LES_ELASTIC_OFS, 32'hffff_ffff);
      inject(rows[i].k, rows[i].ln);
      rd(rows[i].k[1] ? `LES_ELASTIC_OFS : `LES_CODING_OFS);
      exp_word = 32'(rows[i].ex) << (rows[i].k[0] ? 16 : 0);
      `CHK(rd_word, exp_word)
      exp_word = 32'(rows[i].ex) << (24 - 8 * rows[i].k);
      `CHK({df, cf, uf, of}, exp_word)
      `CHK(lv, (rows[i].odd || !rows[i].mrg) ? 8'h0f : 8'hff)
    end
    @(posedge clk_in);
    ltssm_in <= lane_error_status_pkg::LTSSM_L0;
    port_odd_in <= 1'b0; merged_mode_in <= 1'b1;
    inject(2'h0, 8'h0f);
    wr(`LES_CODING_OFS, 32'hff00_0005);
    rd(`LES_CODING_OFS);
    `CHK(rd_word, 32'h0000_000a)
    wr(`LES_CODING_MASK_OFS, 32'h0000_0002);
    @(negedge clk_in); `CHK(irq_out, 1'b1)
    wr(`LES_CODING_MASK_OFS, 32'h0000_0004);
    @(negedge clk_in); `CHK(irq_out, 1'b0)
    wr(`LES_CODING_MASK_OFS, 32'h0000_0002);
    wr(`LES_CODING_OFS, 32'h0000_0002);
    @(negedge clk_in); `CHK(irq_out, 1'b0)
    inject(2'h2, 8'h01);
    wr(`LES_ELASTIC_MASK_OFS, 32'h0000_0001);
    @(negedge clk_in);
    `CHK(irq_out, 1'b1)
    rd(`LES_ELASTIC_MASK_OFS);
    `CHK(rd_word, 32'h0000_0001)
    @(posedge clk_in);
    soft_rst_b_in <= 1'b0;
    @(posedge clk_in); soft_rst_b_in <= 1'b1;
    rd(`LES_CODING_OFS);
    `CHK(rd_word, 32'h0)
    rd(`LES_ELASTIC_OFS);
    `CHK(rd_word, 32'h0000_0001)
    `CHK(irq_out, 1'b0)
    @(posedge clk_in); rst_b_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd(`LES_ELASTIC_OFS);
    `CHK(rd_word, 32'h0)
    final_report();
  end
endmodule : lane_error_status_tb_top
